/* File: hw/rcm_ctrl.sv */
// regulator mode and temperature indicator control with apb register access
`timescale 1ns/1ps
module rcm_ctrl
  import rcm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // core status, same clock
  input wire logic SLEEP_ACTIVE,
  input wire logic EXT_CLOCK_MODE,
  input wire logic [2:0] INTERNAL_OSC_CODE,
  input wire logic FAST_INTERNAL_OSC_PERIPH,
  input wire logic PERIPH_ACTIVE,
  input wire logic BROWNOUT_RESET_EN,
  input wire logic SELF_WRITE_ACTIVE,
  input wire logic CONV_ACTIVE,
  input wire logic [2:0] CONV_CHANNEL,
  // analog status, asynchronous
  input wire logic SUPPLY_LOW,
  input wire logic VREF_READY,
  // regulator control
  output rcm_mode_t REG_MODE,
  output logic REG_DISABLE,
  // temperature indicator and reference control
  output logic TEMP_SENSE_ON,
  output logic TEMP_RANGE_HIGH,
  output logic TEMP_CH_SEL,
  output logic VREF_ON,
  output logic [1:0] VREF_GAIN
);

  // synchronised analog flags
  logic [1:0] ana_sync;
  logic supply_low_s;
  logic vref_ready_s;

  rcm_sync #(
    .W(2)
  ) u_sync (
    .clk(CLK),
    .rstn(RSTN),
    .din({SUPPLY_LOW, VREF_READY}),
    .dout(ana_sync)
  );

  assign supply_low_s = ana_sync[1];
  assign vref_ready_s = ana_sync[0];

  // register state
  logic vref_en_q;
  logic temp_en_q;
  logic temp_rng_q;
  logic [1:0] gain_q;
  logic pm_sel_q;
  logic keep_q;

  // apb decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic err_q;

  assign setup_ph = PSEL & ~PENABLE;
  assign access_ph = PSEL & PENABLE;
  assign addr_hit = (PADDR == RCM_OFS_VREF) | (PADDR == RCM_OFS_VREG) |
                    (PADDR == RCM_OFS_STAT) | (PADDR == RCM_OFS_TEMP);
  // only byte lane 0 carries writable register data
  assign wr_en = access_ph & PWRITE & PSTRB[0] & addr_hit;

  // never stretched: answer comes in the first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph & err_q;
  assign PRDATA = rdata_q;

  // voltage reference control writes
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      vref_en_q <= RCM_VREF_RESET[RCM_VREF_EN_BIT];
      temp_en_q <= RCM_VREF_RESET[RCM_TEMP_EN_BIT];
      temp_rng_q <= RCM_VREF_RESET[RCM_TEMP_RNG_BIT];
      gain_q <= RCM_VREF_RESET[RCM_GAIN_LSB +: 2];
    end else if (wr_en && PADDR == RCM_OFS_VREF) begin
      vref_en_q <= PWDATA[RCM_VREF_EN_BIT];
      temp_en_q <= PWDATA[RCM_TEMP_EN_BIT];
      temp_rng_q <= PWDATA[RCM_TEMP_RNG_BIT];
      gain_q <= PWDATA[RCM_GAIN_LSB +: 2];
    end
  end

  // regulator control writes
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pm_sel_q <= RCM_VREG_RESET[RCM_PM_SEL_BIT];
      keep_q <= RCM_VREG_RESET[RCM_KEEP_BIT];
    end else if (wr_en && PADDR == RCM_OFS_VREG) begin
      pm_sel_q <= PWDATA[RCM_PM_SEL_BIT];
      keep_q <= PWDATA[RCM_KEEP_BIT];
    end
  end

  // regulator mode decision
  rcm_core_t core;
  rcm_mode_t mode_q;
  logic forced_q;

  // one driver for the whole status word
  assign core = '{
    sleep: SLEEP_ACTIVE,
    ext_clk: EXT_CLOCK_MODE,
    osc_code: INTERNAL_OSC_CODE,
    fast_osc_periph: FAST_INTERNAL_OSC_PERIPH,
    periph_active: PERIPH_ACTIVE,
    brownout_en: BROWNOUT_RESET_EN,
    self_write: SELF_WRITE_ACTIVE,
    conv_active: CONV_ACTIVE,
    supply_low: supply_low_s
  };

  rcm_mode_sel u_mode (
    .clk(CLK),
    .rstn(RSTN),
    .core(core),
    .pm_sel(pm_sel_q),
    .mode_q(mode_q),
    .forced_q(forced_q)
  );

  assign REG_MODE = mode_q;
  assign REG_DISABLE = (mode_q == RCM_MODE_TRACK);

  // temperature indicator and reference outputs
  logic ch_sel_q;
  logic ts_on_q;
  logic ts_rng_q;
  logic vref_on_q;
  logic [1:0] vref_gain_q;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ts_on_q <= 1'b0;
      ts_rng_q <= 1'b0;
      ch_sel_q <= 1'b0;
      vref_on_q <= 1'b0;
      vref_gain_q <= 2'h0;
    end else begin
      ts_on_q <= temp_en_q;
      ts_rng_q <= temp_rng_q;
      ch_sel_q <= (CONV_CHANNEL == RCM_CH_TEMP);
      vref_on_q <= vref_en_q;
      // buffers off whenever the reference itself is off
      vref_gain_q <= vref_en_q ? gain_q : 2'h0;
    end
  end

  assign TEMP_SENSE_ON = ts_on_q;
  assign TEMP_RANGE_HIGH = ts_rng_q;
  assign TEMP_CH_SEL = ch_sel_q;
  assign VREF_ON = vref_on_q;
  assign VREF_GAIN = vref_gain_q;

  // settle tracking: software must honour the wait, the block only reports it
  logic ch_sel_d1_q;
  logic conv_d1_q;
  logic settle_start;
  logic [11:0] settle_cnt_q;
  logic settled_q;
  logic early_conv_q;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ch_sel_d1_q <= 1'b0;
      conv_d1_q <= 1'b0;
    end else begin
      ch_sel_d1_q <= ch_sel_q;
      conv_d1_q <= CONV_ACTIVE;
    end
  end

  // restart on channel switch or conversion end
  assign settle_start = (ch_sel_q & ~ch_sel_d1_q) | (ch_sel_q & conv_d1_q & ~CONV_ACTIVE);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      settle_cnt_q <= 12'h000;
      settled_q <= 1'b0;
    end else if (!ch_sel_q || !ts_on_q) begin
      settle_cnt_q <= 12'h000;
      settled_q <= 1'b0;
    end else if (settle_start) begin
      settle_cnt_q <= RCM_SETTLE_CNT;
      settled_q <= 1'b0;
    end else if (settle_cnt_q != 12'h000) begin
      settle_cnt_q <= settle_cnt_q - 12'h001;
      settled_q <= (settle_cnt_q == 12'h001);
    end
  end

  // sticky flag for a conversion started before the indicator settled
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      early_conv_q <= 1'b0;
    end else if (ch_sel_q && CONV_ACTIVE && !conv_d1_q && !settled_q) begin
      // set wins over a clear in the same cycle
      early_conv_q <= 1'b1;
    end else if (wr_en && PADDR == RCM_OFS_TEMP && PWDATA[1]) begin
      early_conv_q <= 1'b0;
    end
  end

  // read mux, registered in the setup cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (PADDR)
      RCM_OFS_VREF: begin
        rdata_d[RCM_VREF_EN_BIT] = vref_en_q;
        rdata_d[RCM_VREF_RDY_BIT] = vref_ready_s & vref_en_q;
        rdata_d[RCM_TEMP_EN_BIT] = temp_en_q;
        rdata_d[RCM_TEMP_RNG_BIT] = temp_rng_q;
        rdata_d[RCM_GAIN_LSB +: 2] = gain_q;
      end
      RCM_OFS_VREG: begin
        rdata_d[RCM_PM_SEL_BIT] = pm_sel_q;
        rdata_d[RCM_KEEP_BIT] = keep_q;
      end
      RCM_OFS_STAT: begin
        rdata_d[1:0] = mode_q;
        rdata_d[2] = forced_q;
        rdata_d[3] = supply_low_s;
        rdata_d[4] = SLEEP_ACTIVE;
      end
      RCM_OFS_TEMP: begin
        rdata_d[0] = settled_q;
        rdata_d[1] = early_conv_q;
        rdata_d[2] = ch_sel_q;
        rdata_d[15:4] = settle_cnt_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup_ph) begin
      rdata_q <= PWRITE ? 32'h0000_0000 : rdata_d;
      err_q <= ~addr_hit;
    end
  end

endmodule

/* File: hw/rcm_pkg.sv */
// shared constants and types for the regulator mode and temperature sense control
// Contract
// - awake, external or 16 MHz: high mode
// - awake, 31 to 500 kHz: low mode
// - asleep, mode select clear: low mode
// - asleep, select set, quiet: power-save mode
// - force conditions turn power-save into low
// - supply low: tracking, regulator off, overrides all
// - regulator control bit 1 mode select, resets 0
// - regulator control bit 0 resets 1, keep set
// - regulator control bits 7-2 read zero
// - temperature indicator on only while enabled
// - range select 1 high, 0 low
// - temperature indicator has own converter channel
// - temp sense enable at reference bit 5
// - range select at reference bit 4, resets 0
package rcm_pkg;

  // register byte offsets
  localparam logic [7:0] RCM_OFS_VREF = 8'h00;
  localparam logic [7:0] RCM_OFS_VREG = 8'h04;
  localparam logic [7:0] RCM_OFS_STAT = 8'h08;
  localparam logic [7:0] RCM_OFS_TEMP = 8'h0c;

  // voltage reference control fields
  localparam int RCM_VREF_EN_BIT = 7;
  localparam int RCM_VREF_RDY_BIT = 6;
  localparam int RCM_TEMP_EN_BIT = 5;
  localparam int RCM_TEMP_RNG_BIT = 4;
  localparam int RCM_GAIN_LSB = 0;
  localparam logic [7:0] RCM_VREF_RESET = 8'h00;

  // regulator control fields
  localparam int RCM_PM_SEL_BIT = 1;
  localparam int RCM_KEEP_BIT = 0;
  localparam logic [1:0] RCM_VREG_RESET = 2'h1;

  // internal oscillator frequency codes
  localparam logic [2:0] RCM_OSC_16M = 3'h7;
  localparam logic [2:0] RCM_OSC_1M = 3'h3;

  // converter channel code of the temperature indicator
  localparam logic [2:0] RCM_CH_TEMP = 3'h6;

  // temperature settle time
  localparam int RCM_CLK_PERIOD_NS = 50;
  localparam int RCM_SETTLE_NS = 200000;
  localparam int RCM_SETTLE_CYC = (RCM_SETTLE_NS + RCM_CLK_PERIOD_NS - 1) / RCM_CLK_PERIOD_NS;
  localparam logic [11:0] RCM_SETTLE_CNT = 12'(RCM_SETTLE_CYC);

  typedef enum logic [1:0] {
    RCM_MODE_HIGH,
    RCM_MODE_LOW,
    RCM_MODE_PSAVE,
    RCM_MODE_TRACK
  } rcm_mode_t;

  // core status that steers the regulator mode
  typedef struct packed {
    logic sleep;
    logic ext_clk;
    logic [2:0] osc_code;
    logic fast_osc_periph;
    logic periph_active;
    logic brownout_en;
    logic self_write;
    logic conv_active;
    logic supply_low;
  } rcm_core_t;

endpackage

/* File: hw/rcm_sync.sv */
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module rcm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // async in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk) begin
        if (!rstn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule

/* File: hw/rcm_mode_sel.sv */
// regulator power mode decision, registered
`timescale 1ns/1ps
module rcm_mode_sel
  import rcm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // decision inputs
  input wire rcm_core_t core,
  input wire logic pm_sel,
  // decision
  output rcm_mode_t mode_q,
  output logic forced_q
);
  rcm_mode_t mode_d;
  logic force_low;

  assign force_low = core.brownout_en | core.fast_osc_periph | core.self_write |
                     core.conv_active;

  always_comb begin
    mode_d = RCM_MODE_LOW;
    if (core.supply_low) begin
      mode_d = RCM_MODE_TRACK;
    end else if (core.sleep) begin
      if (pm_sel && !core.periph_active && !force_low) begin
        mode_d = RCM_MODE_PSAVE;
      end else begin
        mode_d = RCM_MODE_LOW;
      end
    end else if (core.ext_clk || core.osc_code >= RCM_OSC_1M) begin
      mode_d = RCM_MODE_HIGH;
    end else begin
      mode_d = RCM_MODE_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_q <= RCM_MODE_LOW;
      forced_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      forced_q <= core.sleep & pm_sel & force_low & ~core.supply_low;
    end
  end
endmodule

/* File: tb/rcm_ctrl_asserts.sv */
// checker for regulator mode and temperature indicator control
`timescale 1ns/1ps
module rcm_ctrl_asserts
  import rcm_pkg::*;
(
  // clock, reset and apb
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  // core status
  input wire logic SLEEP_ACTIVE,
  input wire logic EXT_CLOCK_MODE,
  input wire logic [2:0] INTERNAL_OSC_CODE,
  input wire logic FAST_INTERNAL_OSC_PERIPH,
  input wire logic PERIPH_ACTIVE,
  input wire logic BROWNOUT_RESET_EN,
  input wire logic SELF_WRITE_ACTIVE,
  input wire logic CONV_ACTIVE,
  input wire logic SUPPLY_LOW,
  // outputs
  input wire rcm_mode_t REG_MODE,
  input wire logic REG_DISABLE,
  input wire logic TEMP_SENSE_ON,
  input wire logic TEMP_RANGE_HIGH
);
  logic pm_q;
  logic [2:0] calm_q;
  logic wr;
  logic frc;
  logic quiet;
  logic calm;
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign frc = BROWNOUT_RESET_EN | FAST_INTERNAL_OSC_PERIPH | SELF_WRITE_ACTIVE | CONV_ACTIVE;
  assign quiet = SLEEP_ACTIVE && pm_q && !PERIPH_ACTIVE && !frc;
  // the supply synchroniser and mode register need three edges to clear after a low supply
  assign calm = calm_q > 3'h4;
  always_ff @(posedge CLK) begin
    if (!RSTN)
      pm_q <= 1'b0;
    else if (wr && PADDR == RCM_OFS_VREG)
      pm_q <= PWDATA[1];
  end
  always_ff @(posedge CLK) begin
    if (!RSTN || SUPPLY_LOW)
      calm_q <= 3'h0;
    else if (calm_q != 3'h7)
      calm_q <= calm_q + 3'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  chk_awake_high:
  assert property (calm && !$past(SLEEP_ACTIVE) && ($past(EXT_CLOCK_MODE) ||
    $past(INTERNAL_OSC_CODE) >= RCM_OSC_1M) |-> REG_MODE == RCM_MODE_HIGH)
    else $error("awake mode not high");
  chk_awake_low:
  assert property (calm && !$past(SLEEP_ACTIVE) && !$past(EXT_CLOCK_MODE) &&
    $past(INTERNAL_OSC_CODE) < RCM_OSC_1M |-> REG_MODE == RCM_MODE_LOW)
    else $error("slow awake mode not low");
  chk_sleep_low:
  assert property (calm && $past(SLEEP_ACTIVE) && !$past(pm_q) |-> REG_MODE == RCM_MODE_LOW)
    else $error("sleep mode not low");
  chk_sleep_psave:
  assert property (calm && $past(quiet) |-> REG_MODE == RCM_MODE_PSAVE)
    else $error("quiet sleep not power save");
  chk_force_low:
  assert property (calm && $past(SLEEP_ACTIVE) && $past(pm_q) && $past(frc) |->
    REG_MODE == RCM_MODE_LOW) else $error("forced sleep not low");
  chk_supply_track:
  assert property (SUPPLY_LOW [*4] |-> REG_MODE == RCM_MODE_TRACK && REG_DISABLE)
    else $error("low supply not tracking");
  chk_sense_enable:
  assert property (wr && PADDR == RCM_OFS_VREF |-> ##2 TEMP_SENSE_ON == $past(PWDATA[5], 2))
    else $error("sense enable wrong");
  chk_range_sel:
  assert property (wr && PADDR == RCM_OFS_VREF |-> ##2 TEMP_RANGE_HIGH == $past(PWDATA[4], 2))
    else $error("range select wrong");
endmodule
bind rcm_ctrl rcm_ctrl_asserts u_rcm_ctrl_asserts (.*);

/* File: tb/rcm_core_model.sv */
// core status model: registers each requested status change except a temperature channel conversion inside settle time
`timescale 1ns/1ps
module rcm_core_model
  import rcm_pkg::*;
(
  // clock and requested status
  input wire logic clk,
  input wire rcm_core_t req,
  input wire logic [2:0] req_ch,
  // status seen by the block
  output rcm_core_t core,
  output logic [2:0] ch
);
  logic [11:0] wait_q = 12'h000;
  // no temperature conversion inside settle time
  always_ff @(posedge clk) begin
    core <= req;
    ch <= req_ch;
    if (req_ch == RCM_CH_TEMP && wait_q != 12'h000)
      core.conv_active <= 1'b0;
  end
  // settle time restarts on channel switch or conversion end
  always_ff @(posedge clk) begin
    // the block starts its own count up to two edges later, so keep a margin
    if (req_ch != ch || (core.conv_active && !req.conv_active))
      wait_q <= RCM_SETTLE_CNT + 12'h004;
    else if (wait_q != 12'h000)
      wait_q <= wait_q - 12'h001;
  end
endmodule

/* File: tb/tb.sv */
// testbench: apb register checks, temperature indicator, mode table
`timescale 1ns/1ps
module tb;
  import rcm_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, ts_on, ts_hi, ch_sel, dis;
  logic vref_on, frc_exp;
  logic [1:0] vref_gain;
  logic [3:0] pstrb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] req_ch, ch;
  rcm_core_t req, core;
  rcm_mode_t mode;
  int num_errors, compares;
  // {mode, 0, sleep select, 0, core status}
  logic [15:0] tbl [14] = '{16'h0200, 16'h01c0, 16'h00c0, 16'h4080, 16'h4000, 16'h45c0,
    16'h9400, 16'h5410, 16'h5420, 16'h5408, 16'h5404, 16'h5402, 16'hc201, 16'hd401};
  rcm_core_model u_rcm_core_model (.clk(clk), .req(req), .req_ch(req_ch), .core(core), .ch(ch));
  rcm_ctrl u_rcm_ctrl (.CLK(clk), .RSTN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SLEEP_ACTIVE(core.sleep), .EXT_CLOCK_MODE(core.ext_clk),
    .INTERNAL_OSC_CODE(core.osc_code), .FAST_INTERNAL_OSC_PERIPH(core.fast_osc_periph),
    .PERIPH_ACTIVE(core.periph_active), .BROWNOUT_RESET_EN(core.brownout_en),
    .SELF_WRITE_ACTIVE(core.self_write), .CONV_ACTIVE(core.conv_active),
    .CONV_CHANNEL(ch), .SUPPLY_LOW(core.supply_low), .VREF_READY(1'b1), .REG_MODE(mode),
    .REG_DISABLE(dis), .TEMP_SENSE_ON(ts_on), .TEMP_RANGE_HIGH(ts_hi),
    .TEMP_CH_SEL(ch_sel), .VREF_ON(vref_on), .VREF_GAIN(vref_gain));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; data and error are taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      finish_test;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    req = '0;
    req_ch = 3'h0;
    num_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, RCM_OFS_VREF, 32'h0);
    chk("vref reset", 32'h0, rd);
    apb(1'b0, RCM_OFS_VREG, 32'h0);
    chk("vreg reset", 32'h1, rd);
    apb(1'b1, RCM_OFS_VREG, 32'hffffffff);
    apb(1'b0, RCM_OFS_VREG, 32'h0);
    chk("vreg bits", 32'h3, rd);
    pstrb <= 4'he;
    apb(1'b1, RCM_OFS_VREG, 32'h1);
    pstrb <= 4'hf;
    apb(1'b0, RCM_OFS_VREG, 32'h0);
    chk("strobe ignored", 32'h3, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");
    apb(1'b1, RCM_OFS_VREF, 32'h30);
    settle(2);
    chk("sense on", 32'h1, {31'h0, ts_on});
    chk("range high", 32'h1, {31'h0, ts_hi});
    apb(1'b1, RCM_OFS_VREF, 32'h20);
    settle(2);
    chk("range low", 32'h0, {31'h0, ts_hi});
    @(posedge clk);
    req_ch <= RCM_CH_TEMP;
    settle(3);
    chk("temp channel", 32'h1, {31'h0, ch_sel});
    @(posedge clk);
    req.conv_active <= 1'b1;
    apb(1'b0, RCM_OFS_TEMP, 32'h0);
    chk("temp early", 32'h4, rd & 32'h7);
    settle(4020);
    apb(1'b0, RCM_OFS_TEMP, 32'h0);
    chk("temp settled", 32'h5, rd & 32'h7);
    req.conv_active <= 1'b0;
    settle(3);
    apb(1'b0, RCM_OFS_TEMP, 32'h0);
    chk("temp resettle", 32'h4, rd & 32'h7);
    req.conv_active <= 1'b1;
    settle(3);
    apb(1'b0, RCM_OFS_TEMP, 32'h0);
    chk("temp spacing", 32'h4, rd & 32'h7);
    req.conv_active <= 1'b0;
    apb(1'b1, RCM_OFS_VREF, 32'h0);
    settle(2);
    chk("sense off", 32'h0, {31'h0, ts_on});
    apb(1'b1, RCM_OFS_VREF, 32'h83);
    settle(2);
    chk("vref gain on", 32'h7, {29'h0, vref_on, vref_gain});
    apb(1'b0, RCM_OFS_VREF, 32'h0);
    chk("vref read", 32'hc3, rd);
    apb(1'b1, RCM_OFS_VREF, 32'h03);
    settle(2);
    chk("vref gain off", 32'h0, {29'h0, vref_on, vref_gain});
    $display("test temperature done");
    @(posedge clk);
    req_ch <= 3'h0;
    foreach (tbl[i]) begin
      apb(1'b1, RCM_OFS_VREG, {30'h0, tbl[i][12], 1'b1});
      @(posedge clk);
      req <= rcm_core_t'(tbl[i][10:0]);
      settle(7);
      chk("mode", {30'h0, tbl[i][15:14]}, {30'h0, mode});
      chk("disable", {31'h0, tbl[i][0]}, {31'h0, dis});
      apb(1'b0, RCM_OFS_STAT, 32'h0);
      frc_exp = tbl[i][12] & tbl[i][10] & ~tbl[i][0] & (|{tbl[i][5], tbl[i][3:1]});
      chk("status", {27'h0, tbl[i][10], tbl[i][0], frc_exp, tbl[i][15:14]}, rd & 32'h1f);
    end
    $display("test modes done");
    apb(1'b1, RCM_OFS_VREF, 32'h30);
    req <= '0;
    settle(8);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, RCM_OFS_VREG, 32'h0);
    chk("vreg rearm", 32'h1, rd);
    apb(1'b0, RCM_OFS_VREF, 32'h0);
    chk("vref rearm", 32'h0, rd);
    chk("sense rearm", 32'h0, {31'h0, ts_on});
    $display("test reset done");
    finish_test;
  end
endmodule
